// ==== dv/adc_serial_readout_test.sv ====
// self-checking bench for the serial read-out block
`timescale 1ns/10ps
module adc_serial_readout_test;
  localparam int unsigned ST = 50, SE = 150, PER = 2000, GU = 20;
  logic        clk, rstn, cyc, stb, we, ack, irq, pd_n, sclk, dout, oe, oor, flt, line, start, done;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, rd;
  logic [15:0] code;
  logic [4:0]  nbits;
  logic [23:0] word;
  int          error_cnt, n_compared, cyc_cnt, t0, t1, k;
`define ASR_CHECK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
  asr_top #(.STARTUP_CYCLES(ST), .SETTLE_CYCLES(SE), .PERIOD_CYCLES(PER), .GUARD_CYCLES(GU)) dut (
    .clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq),
    .power_down_reset_n(pd_n), .sclk(sclk), .dout_rdy_o(dout), .dout_rdy_oe(oe),
    .conv_code(code), .conv_out_of_range(oor));
  asr_host_model host (.clk(clk), .line(line), .start(start), .nbits(nbits), .sclk(sclk),
    .word(word), .done(done));
  // released pin shows a changing level
  assign line = oe ? dout : flt;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    flt <= ~flt;
    cyc_cnt <= cyc_cnt + 1;
  end
  // ==========================================================================
  // bus, link and closing tasks
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin @(posedge clk); end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wait_low(output int t);
    int n;
    n = 0;
    while (line !== 1'b0 && n < 5000) begin @(posedge clk); n++; end
    t = cyc_cnt;
  endtask : wait_low
  task automatic host_read(input logic [4:0] nb);
    int n;
    nbits <= nb; start <= 1'b1; n = 0;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    while (!done && n < 2000) begin @(posedge clk); n++; end
  endtask : host_read
  task automatic stop_test();
    if (error_cnt == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
  // ==========================================================================
  // tests
  initial begin
    rstn = 0; cyc = 0; stb = 0; we = 0; adr = 8'h0; wdat = 32'h0; pd_n = 0; start = 0; nbits = 5'h18;
    code = 16'h8000; oor = 0; flt = 0; cyc_cnt = 0; error_cnt = 0; n_compared = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    bus(0, asr_pkg::ADR_ENABLE, 32'h0); `ASR_CHECK(rd, 32'h0)
    bus(0, asr_pkg::ADR_CLEAR, 32'h0); `ASR_CHECK(rd, 32'h0)
    bus(0, 8'hfc, 32'h0); `ASR_CHECK(rd, 32'h0)
    bus(1, asr_pkg::ADR_STATUS, 32'hf); bus(0, asr_pkg::ADR_STATUS, 32'h0); `ASR_CHECK(rd, 32'h0)
    bus(1, asr_pkg::ADR_CTRL, 32'h1); bus(0, asr_pkg::ADR_CTRL, 32'h0); `ASR_CHECK(rd[1:0], 2'h1)
    bus(1, asr_pkg::ADR_ENABLE, 32'hf);
    `ASR_CHECK(oe, 1'b0)
    pd_n <= 1'b1; t0 = cyc_cnt;
    repeat (10) @(posedge clk);
    `ASR_CHECK({oe, dout}, 2'b11)
    wait_low(t1); `ASR_CHECK(t1 - t0 >= ST + SE, 1'b1)
    host_read(5'h18); `ASR_CHECK(word, {16'h8000, 5'h01, asr_pkg::CHECK_PATTERN})
    `ASR_CHECK(line, 1'b1)
    repeat (100) @(posedge clk);
    `ASR_CHECK(line, 1'b1)
    bus(0, asr_pkg::ADR_RESULT, 32'h0); `ASR_CHECK(rd, {8'h00, 16'h8000, 8'h0d})
    bus(0, asr_pkg::ADR_COUNT, 32'h0); `ASR_CHECK(rd, 32'h1)
    bus(0, asr_pkg::ADR_STATUS, 32'h0); `ASR_CHECK(rd[3:0], 4'h5)
    `ASR_CHECK(irq, 1'b1)
    bus(1, asr_pkg::ADR_ENABLE, 32'h0); repeat (2) @(posedge clk); `ASR_CHECK(irq, 1'b0)
    bus(1, asr_pkg::ADR_ENABLE, 32'hf); repeat (2) @(posedge clk); `ASR_CHECK(irq, 1'b1)
    bus(1, asr_pkg::ADR_CLEAR, 32'hf); repeat (2) @(posedge clk); `ASR_CHECK(irq, 1'b0)
    for (k = 0; k < 2; k++) begin
      code <= k ? 16'hffff : 16'h0000; oor <= (k == 0);
      wait_low(t0); `ASR_CHECK(t0 - t1, PER)
      t1 = t0;
      host_read(5'h18); `ASR_CHECK(word, {code, 2'b00, oor, 2'h1, 3'h5})
    end
    code <= 16'h1234; oor <= 1'b0;
    wait_low(t1);
    while (cyc_cnt < t1 + PER - 30) @(posedge clk);
    `ASR_CHECK(line, 1'b0)
    while (cyc_cnt < t1 + PER - 8) @(posedge clk);
    `ASR_CHECK(line, 1'b1)
    wait_low(t0); `ASR_CHECK(t0 - t1, PER)
    bus(0, asr_pkg::ADR_STATUS, 32'h0); `ASR_CHECK(rd[1], 1'b1)
    t1 = t0; code <= 16'h00ff;
    host_read(5'h0c);
    while (cyc_cnt < t1 + PER + 10) @(posedge clk);
    bus(0, asr_pkg::ADR_STATUS, 32'h0); `ASR_CHECK(rd[3], 1'b1)
    `ASR_CHECK(irq, 1'b1)
    host_read(5'h18); `ASR_CHECK(word, {16'h00ff, 5'h01, 3'h5})
    stop_test();
  end
endmodule : adc_serial_readout_test

// ==== dv/asr_host_model.sv ====
// host model clocking result words off the serial link
`timescale 1ns/10ps
module asr_host_model (
  input  wire logic       clk,
  input  wire logic       line,
  input  wire logic       start,
  input  wire logic [4:0] nbits,
  output logic            sclk,
  output logic [23:0]     word,
  output logic            done
);
  int i;
  initial begin
    sclk = 1'b1;
    word = 24'h0;
    done = 1'b1;
  end
  // ==========================================================================
  // one frame per start, link clock idle high between frames
  always begin
    @(posedge clk iff start);
    done = 1'b0;
    #1.7;
    for (i = 0; i < nbits; i++) begin
      sclk = 1'b0;
      #80;
      sclk = 1'b1;
      word = {word[22:0], line};
      #80;
    end
    done = 1'b1;
  end
endmodule : asr_host_model

// ==== dv/asr_monitor.sv ====
// port checker for the serial read-out block
`timescale 1ns/10ps
module asr_monitor #(
  parameter int unsigned STARTUP_CYCLES = 50,
  parameter int unsigned SETTLE_CYCLES  = 150
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        power_down_reset_n,
  input wire logic        dout_rdy_o,
  input wire logic        dout_rdy_oe
);
  // ==========================================================================
  // cycles since wake
  logic [31:0] wake_cnt_reg;
  logic        seen_reg;
  always_ff @(posedge clk) begin
    if (!rstn || !dout_rdy_oe) begin
      wake_cnt_reg <= 32'h0;
      seen_reg     <= 1'b0;
    end else begin
      wake_cnt_reg <= wake_cnt_reg + 32'h1;
      if (!dout_rdy_o) begin
        seen_reg <= 1'b1;
      end
    end
  end
  // ==========================================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_pd_held; !power_down_reset_n [*5]; endsequence
  sequence s_pin_up; power_down_reset_n [*5] ##0 dout_rdy_oe; endsequence
  chk_ack_answer: assert property (s_req |=> wb_ack_o) else $error("ack missing");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i)) else $error("ack unasked");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
  chk_read_zero: assert property (s_req ##0 (!wb_we_i && (wb_adr_i == asr_pkg::ADR_CLEAR
    || wb_adr_i > asr_pkg::ADR_COUNT)) |=> wb_dat_o == 32'h0) else $error("refused read not zero");
  chk_pd_tristate: assert property (s_pd_held |-> !dout_rdy_oe) else $error("line driven");
  chk_wake_high: assert property ($rose(dout_rdy_oe) |-> dout_rdy_o) else $error("wake low");
  chk_oe_hold: assert property (s_pin_up |=> dout_rdy_oe) else $error("line released");
  chk_settle_first: assert property ($fell(dout_rdy_o) && !seen_reg && dout_rdy_oe
    |-> wake_cnt_reg >= 32'(STARTUP_CYCLES + SETTLE_CYCLES - 4)) else $error("early result");
endmodule : asr_monitor
bind asr_top asr_monitor #(.STARTUP_CYCLES(STARTUP_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)) u_mon (
  .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .power_down_reset_n(power_down_reset_n), .dout_rdy_o(dout_rdy_o), .dout_rdy_oe(dout_rdy_oe));

// ==== hdl/asr_pkg.sv ====
// constants and types shared by the serial read-out block
package asr_pkg;

  // ==========================================================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS    = 5;
  localparam int unsigned CLK_FREQ_HZ      = 200_000_000;
  localparam int unsigned STARTUP_NS       = 1_000_000;
  localparam int unsigned SETTLE_NS        = 24_000_000;
  localparam int unsigned OUTPUT_RATE_HZ   = 125;
  localparam int unsigned GUARD_NS         = 2_000;
  localparam int unsigned STARTUP_CYCLES   = STARTUP_NS / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_CYCLES    = SETTLE_NS / CLK_PERIOD_NS;
  localparam int unsigned PERIOD_CYCLES    = CLK_FREQ_HZ / OUTPUT_RATE_HZ;
  localparam int unsigned GUARD_CYCLES     = (GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // result word layout
  localparam int unsigned WORD_BITS        = 24;
  localparam int unsigned CODE_BITS        = 16;
  localparam logic [2:0]  CHECK_PATTERN    = 3'h5;
  localparam logic [1:0]  PART_ID_RESET    = 2'h2;  // arbitrary value
  localparam logic        RDY_BIT_VALUE    = 1'h0;
  localparam logic        ZERO_BIT_VALUE   = 1'h0;

  // ==========================================================================
  // register map
  localparam logic [7:0]  ADR_STATUS       = 8'h00;
  localparam logic [7:0]  ADR_CLEAR        = 8'h04;
  localparam logic [7:0]  ADR_ENABLE       = 8'h08;
  localparam logic [7:0]  ADR_CTRL         = 8'h0c;
  localparam logic [7:0]  ADR_RESULT       = 8'h10;
  localparam logic [7:0]  ADR_STATE        = 8'h14;
  localparam logic [7:0]  ADR_COUNT        = 8'h18;
  localparam int unsigned EVT_BITS         = 4;
  localparam int unsigned EVT_CONV_DONE    = 0;
  localparam int unsigned EVT_OVERWRITE    = 1;
  localparam int unsigned EVT_READ_DONE    = 2;
  localparam int unsigned EVT_READ_ABORT   = 3;
  localparam logic [3:0]  ENABLE_RESET     = 4'h0;

  // ==========================================================================
  // line states
  typedef enum logic [2:0] {
    ASR_ST_PD,
    ASR_ST_WAKE,
    ASR_ST_IDLE,
    ASR_ST_READY,
    ASR_ST_SHIFT
  } asr_state_t;

endpackage : asr_pkg

// ==== hdl/asr_sync.sv ====
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
module asr_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_value,
  output logic      [WIDTH-1:0] sync_out
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } asr_sync_t;

  asr_sync_t s_reg;
  asr_sync_t s_next;

  always_comb begin
    s_next        = s_reg;
    s_next.meta   = async_in;
    s_next.stable = s_reg.meta;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_reg <= '{meta: reset_value, stable: reset_value};
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_out = rstn ? s_reg.stable : reset_value;

endmodule : asr_sync

// ==== hdl/asr_timer.sv ====
// wake-up, settling and conversion period timer
`timescale 1ns/10ps
module asr_timer #(
  parameter int unsigned STARTUP_CYCLES = asr_pkg::STARTUP_CYCLES,
  parameter int unsigned SETTLE_CYCLES  = asr_pkg::SETTLE_CYCLES,
  parameter int unsigned PERIOD_CYCLES  = asr_pkg::PERIOD_CYCLES,
  parameter int unsigned GUARD_CYCLES   = asr_pkg::GUARD_CYCLES
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic run,
  output logic      pre_update,
  output logic      conv_done
);

  localparam logic [31:0] FIRST_LIMIT  = 32'(STARTUP_CYCLES + SETTLE_CYCLES);
  localparam logic [31:0] PERIOD_LIMIT = 32'(PERIOD_CYCLES);
  localparam logic [31:0] GUARD        = 32'(GUARD_CYCLES);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [31:0] count;
    logic        first;
    logic        pre;
    logic        done;
  } asr_timer_t;

  asr_timer_t t_reg;
  asr_timer_t t_next;
  logic [31:0] limit;

  always_comb begin
    t_next      = t_reg;
    t_next.pre  = 1'b0;
    t_next.done = 1'b0;
    limit       = t_reg.first ? FIRST_LIMIT : PERIOD_LIMIT;
    if (!run) begin
      t_next.count = '0;
      t_next.first = 1'b1;
    end else if (t_reg.count == limit - 32'h1) begin
      t_next.count = '0;
      t_next.first = 1'b0;
      t_next.done  = 1'b1;
    end else begin
      t_next.count = t_reg.count + 32'h1;
      t_next.pre   = (t_reg.count == limit - GUARD - 32'h1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      t_reg <= '{count: '0, first: 1'b1, pre: 1'b0, done: 1'b0};
    end else begin
      t_reg <= t_next;
    end
  end

  assign pre_update = t_reg.pre;
  assign conv_done  = t_reg.done;

endmodule : asr_timer

// ==== hdl/asr_top.sv ====
// serial read-out and conversion sequencing with wishbone registers
// Operation
// - trailing status bits always carry 101
// - line returns high after full word
// - unread result: line high before update
// - each result offered for one read
// - conversion end resets interface, loads result
// - line tristated while power-down held low
// - wait start-up then convert continuously
// - first result after full settling time
// - line high on wake, low when valid
// - results follow at fixed output rate
// - line low once new word loaded
// - word: 16-bit code then eight status bits
// - error bit set on out-of-range input
// - code in offset binary
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps
module asr_top #(
  parameter int unsigned STARTUP_CYCLES = asr_pkg::STARTUP_CYCLES,
  parameter int unsigned SETTLE_CYCLES  = asr_pkg::SETTLE_CYCLES,
  parameter int unsigned PERIOD_CYCLES  = asr_pkg::PERIOD_CYCLES,
  parameter int unsigned GUARD_CYCLES   = asr_pkg::GUARD_CYCLES,
  parameter logic [1:0]  PART_ID        = asr_pkg::PART_ID_RESET
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq,
  input  wire logic        power_down_reset_n,
  input  wire logic        sclk,
  output logic             dout_rdy_o,
  output logic             dout_rdy_oe,
  input  wire logic [15:0] conv_code,
  input  wire logic        conv_out_of_range
);

  // ==========================================================================
  // state
  typedef struct packed {
    asr_pkg::asr_state_t                  state;
    logic [asr_pkg::WORD_BITS-1:0]        shift;
    logic [asr_pkg::WORD_BITS-1:0]        result;
    logic [4:0]                           bit_cnt;
    logic                                 sclk_prev;
    logic                                 dout;
    logic                                 oe;
    logic [asr_pkg::EVT_BITS-1:0]         status;
    logic [asr_pkg::EVT_BITS-1:0]         enable;
    logic [1:0]                           part_id;
    logic [15:0]                          conv_count;
    logic                                 irq;
    logic                                 ack;
    logic [31:0]                          dat;
  } asr_top_t;

  asr_top_t                      r_reg;
  asr_top_t                      r_next;
  logic [1:0]                    pins_sync;
  logic                          pd_n_s;
  logic                          sclk_s;
  logic                          pre_update;
  logic                          conv_done;
  logic                          sclk_fall;
  logic                          sclk_rise;
  logic                          bus_req;
  logic                          bus_wr;
  logic [asr_pkg::EVT_BITS-1:0]  evt;
  logic [asr_pkg::EVT_BITS-1:0]  clr;

  // ==========================================================================
  // helpers
  function automatic logic [asr_pkg::WORD_BITS-1:0] make_word(
    input logic [15:0] code,
    input logic        err,
    input logic [1:0]  id
  );
    make_word = {code,
                 asr_pkg::RDY_BIT_VALUE, asr_pkg::ZERO_BIT_VALUE,
                 err,
                 id,
                 asr_pkg::CHECK_PATTERN};
  endfunction : make_word

  function automatic logic [7:0] merge_byte(
    input logic [7:0] old_val,
    input logic [7:0] new_val,
    input logic       lane
  );
    merge_byte = lane ? new_val : old_val;
  endfunction : merge_byte

  // ==========================================================================
  // pin synchronisers and conversion timer
  asr_sync #(
    .WIDTH       (2)
  ) u_sync (
    .clk         (clk),
    .rstn        (rstn),
    .async_in    ({power_down_reset_n, sclk}),
    .reset_value (2'h1),
    .sync_out    (pins_sync)
  );

  assign pd_n_s = pins_sync[1];
  assign sclk_s = pins_sync[0];

  asr_timer #(
    .STARTUP_CYCLES (STARTUP_CYCLES),
    .SETTLE_CYCLES  (SETTLE_CYCLES),
    .PERIOD_CYCLES  (PERIOD_CYCLES),
    .GUARD_CYCLES   (GUARD_CYCLES)
  ) u_timer (
    .clk            (clk),
    .rstn           (rstn),
    .run            (pd_n_s),
    .pre_update     (pre_update),
    .conv_done      (conv_done)
  );

  // ==========================================================================
  // link clock edges and bus strobes
  assign sclk_fall = r_reg.sclk_prev & ~sclk_s;
  assign sclk_rise = ~r_reg.sclk_prev & sclk_s;
  assign bus_req   = wb_cyc_i & wb_stb_i;
  assign bus_wr    = bus_req & wb_we_i & r_reg.ack;

  // ==========================================================================
  // next state
  always_comb begin
    r_next           = r_reg;
    r_next.sclk_prev = sclk_s;
    evt              = '0;
    clr              = '0;

    // line sequencing
    if (!pd_n_s) begin
      r_next.state   = asr_pkg::ASR_ST_PD;
      r_next.oe      = 1'b0;
      r_next.dout    = 1'b1;
      r_next.bit_cnt = '0;
    end else if (r_reg.state == asr_pkg::ASR_ST_PD) begin
      r_next.state   = asr_pkg::ASR_ST_WAKE;
      r_next.oe      = 1'b1;
      r_next.dout    = 1'b1;
    end else if (conv_done) begin
      // interface reset and new word in one step
      r_next.shift   = make_word(conv_code, conv_out_of_range, r_reg.part_id);
      r_next.result  = make_word(conv_code, conv_out_of_range, r_reg.part_id);
      r_next.state   = asr_pkg::ASR_ST_READY;
      r_next.dout    = 1'b0;
      r_next.bit_cnt = '0;
      r_next.conv_count = r_reg.conv_count + 16'h1;
      evt[asr_pkg::EVT_CONV_DONE] = 1'b1;
      if (r_reg.state == asr_pkg::ASR_ST_SHIFT) begin
        evt[asr_pkg::EVT_READ_ABORT] = 1'b1;
      end
    end else begin
      case (r_reg.state)
        asr_pkg::ASR_ST_WAKE: begin
          r_next.dout = 1'b1;
        end
        asr_pkg::ASR_ST_IDLE: begin
          r_next.dout = 1'b1;
        end
        asr_pkg::ASR_ST_READY: begin
          if (pre_update) begin
            r_next.state = asr_pkg::ASR_ST_IDLE;
            r_next.dout  = 1'b1;
            evt[asr_pkg::EVT_OVERWRITE] = 1'b1;
          end else if (sclk_fall) begin
            r_next.state   = asr_pkg::ASR_ST_SHIFT;
            r_next.dout    = r_reg.shift[asr_pkg::WORD_BITS-1];
            r_next.shift   = {r_reg.shift[asr_pkg::WORD_BITS-2:0], 1'b1};
            r_next.bit_cnt = 5'h1;
          end
        end
        asr_pkg::ASR_ST_SHIFT: begin
          if (sclk_fall && r_reg.bit_cnt < 5'(asr_pkg::WORD_BITS)) begin
            r_next.dout    = r_reg.shift[asr_pkg::WORD_BITS-1];
            r_next.shift   = {r_reg.shift[asr_pkg::WORD_BITS-2:0], 1'b1};
            r_next.bit_cnt = r_reg.bit_cnt + 5'h1;
          end else if (sclk_rise && r_reg.bit_cnt == 5'(asr_pkg::WORD_BITS)) begin
            r_next.state   = asr_pkg::ASR_ST_IDLE;
            r_next.dout    = 1'b1;
            r_next.bit_cnt = '0;
            evt[asr_pkg::EVT_READ_DONE] = 1'b1;
          end
        end
        default: begin
          r_next.state = asr_pkg::ASR_ST_IDLE;
          r_next.dout  = 1'b1;
        end
      endcase
    end

    // register writes take effect on the edge that sees ack
    if (bus_wr) begin
      if (wb_adr_i == asr_pkg::ADR_CLEAR) begin
        clr = wb_sel_i[0] ? wb_dat_i[asr_pkg::EVT_BITS-1:0] : '0;
      end else if (wb_adr_i == asr_pkg::ADR_ENABLE) begin
        r_next.enable = merge_byte({4'h0, r_reg.enable}, wb_dat_i[7:0], wb_sel_i[0])
                        [asr_pkg::EVT_BITS-1:0];
      end else if (wb_adr_i == asr_pkg::ADR_CTRL) begin
        r_next.part_id = merge_byte({6'h0, r_reg.part_id}, wb_dat_i[7:0], wb_sel_i[0]) [1:0];
      end
    end

    // sticky status, set wins over clear
    r_next.status = (r_reg.status & ~clr) | evt;
    r_next.irq    = |(r_next.status & r_next.enable);

    // bus answer one cycle after request
    r_next.ack = bus_req & ~r_reg.ack;
    r_next.dat = '0;
    if (bus_req && !r_reg.ack && !wb_we_i) begin
      if (wb_adr_i == asr_pkg::ADR_STATUS) begin
        r_next.dat = {28'h0, r_reg.status};
      end else if (wb_adr_i == asr_pkg::ADR_ENABLE) begin
        r_next.dat = {28'h0, r_reg.enable};
      end else if (wb_adr_i == asr_pkg::ADR_CTRL) begin
        r_next.dat = {30'h0, r_reg.part_id};
      end else if (wb_adr_i == asr_pkg::ADR_RESULT) begin
        r_next.dat = {8'h0, r_reg.result};
      end else if (wb_adr_i == asr_pkg::ADR_STATE) begin
        r_next.dat = {24'h0, r_reg.bit_cnt, r_reg.state};
      end else if (wb_adr_i == asr_pkg::ADR_COUNT) begin
        r_next.dat = {16'h0, r_reg.conv_count};
      end else begin
        r_next.dat = '0;
      end
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      r_reg           <= '0;
      r_reg.state     <= asr_pkg::ASR_ST_PD;
      r_reg.shift     <= '1;
      r_reg.dout      <= 1'b1;
      r_reg.sclk_prev <= 1'b1;
      r_reg.enable    <= asr_pkg::ENABLE_RESET;
      r_reg.part_id   <= PART_ID;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // outputs
  assign wb_dat_o    = r_reg.dat;
  assign wb_ack_o    = r_reg.ack;
  assign irq         = r_reg.irq;
  assign dout_rdy_o  = r_reg.dout;
  assign dout_rdy_oe = r_reg.oe;

endmodule : asr_top
